// [pkg/tecfd_consts.svh]
// offsets, field positions, reset values and counts of the timer block
// assumes inclusion by bare name from the package, the checker and the bench
`ifndef TECFD_CONSTS_SVH
`define TECFD_CONSTS_SVH
`define TECFD_ADDR_W 3
`define TECFD_OFS_CTRL 3'h0
`define TECFD_OFS_DATA 3'h1
`define TECFD_OFS_AUX 3'h2
`define TECFD_OFS_PORT 3'h3
`define TECFD_OFS_INT 3'h4
`define TECFD_CTRL_RST 8'h08
`define TECFD_CTRL_MASK 8'hf8
`define TECFD_AUX_RST 8'h00
`define TECFD_AUX_MASK 8'h3f
`define TECFD_PORT_RST 8'h1c
`define TECFD_PORT_MASK 8'h1f
`define TECFD_INT_RST 8'h00
`define TECFD_INT_MASK 8'h03
`define TECFD_B_MODE_HI 7
`define TECFD_B_MODE_LO 6
`define TECFD_B_SRC 5
`define TECFD_B_RUN 4
`define TECFD_B_EDGE 3
`define TECFD_B_PSC_HI 2
`define TECFD_B_PSC_LO 0
`define TECFD_B_DSEL 3
`define TECFD_B_DEN_HI 5
`define TECFD_B_DEN_LO 4
`define TECFD_B_P0 0
`define TECFD_B_P1 1
`define TECFD_B_TC_DIR 2
`define TECFD_B_PFD_DIR 3
`define TECFD_B_PFDN_DIR 4
`define TECFD_B_IEN 0
`define TECFD_B_IFLAG 1
`define TECFD_DIV4_LAST 2'h3
`define TECFD_CNT_FULL 8'hff
`endif

// [pkg/tecfd_pkg.sv]
// types shared by the timer block and its bench
// assumes the constants header sits beside it
package tecfd_pkg;
	`include "tecfd_consts.svh"

	// operating modes of the counter
	typedef enum logic [1:0] {
		MODE_NONE    = 2'b00,
		MODE_EVENT   = 2'b01,
		MODE_TIMER   = 2'b10,
		MODE_CAPTURE = 2'b11
	} tecfd_mode_t;

	// single-shot capture sequence, gray along idle-armed-count
	typedef enum logic [1:0] {
		CAP_IDLE  = 2'b00,
		CAP_ARMED = 2'b01,
		CAP_COUNT = 2'b11
	} tecfd_cap_t;
endpackage

// [src/tecfd_timer.sv]
// 8-bit count-up timer / event counter with pulse capture and frequency divider
// assumes one 10 MHz clock, inputs synchronous to it, register port master
//
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/100ps

module tecfd_timer
	import tecfd_pkg::*;
#(
	parameter int PSC_W = 7
) (
	// clock, reset, freeze
	input  wire logic                     I_CLK,
	input  wire logic                     I_RESET_N,
	input  wire logic                     I_CE,
	// register port
	input  wire logic [`TECFD_ADDR_W-1:0] I_ADDR,
	input  wire logic [7:0]               I_WDATA,
	input  wire logic                     I_WR,
	input  wire logic                     I_RD,
	output logic      [7:0]               O_RDATA,
	// pins and system
	input  wire logic                     I_TC,
	input  wire logic                     I_LXT,
	input  wire logic                     I_OTHER_OVF,
	input  wire logic                     I_SLEEP,
	output logic                          O_IRQ,
	output logic                          O_WAKE,
	output logic                          O_PFD,
	output logic                          O_PFD_N
);

	// software registers
	logic [7:0]  ctrl;
	logic [7:0]  aux;
	logic [7:0]  port;
	logic        irq_enable;
	logic        irq_flag;
	logic [7:0]  preload;
	logic [7:0]  cnt;

	// clocking and edges
	logic [1:0]       div4;
	logic             lxt_s1;
	logic             lxt_s2;
	logic             lxt_d;
	logic             tc_s1;
	logic             tc_s2;
	logic             tc_d;
	logic [PSC_W-1:0] psc;
	tecfd_cap_t       cap_state;
	logic             pfd_q;

	// decoded fields
	tecfd_mode_t mode;
	logic        run_enable;
	logic        edge_select;
	logic        clock_source_select;
	logic [2:0]  prescaler_ratio;
	logic        divider_source_select;
	logic [1:0]  divider_output_enable;

	// combinational terms
	logic             wr_ctrl;
	logic             wr_data;
	logic             src_tick;
	logic             int_tick;
	logic [PSC_W-1:0] psc_mask;
	logic             tc_ok;
	logic             tc_rise;
	logic             tc_fall;
	logic             start_edge;
	logic             stop_edge;
	logic             cap_stop;
	logic             counting;
	logic             tick;
	logic             ovf;
	logic [7:0]       reload;
	logic             sel_ovf;
	logic             next_pfd;
	logic             pfd_act;
	logic             pfdn_act;

	// field decode
	assign mode                  = tecfd_mode_t'(ctrl[`TECFD_B_MODE_HI:`TECFD_B_MODE_LO]);
	assign clock_source_select   = ctrl[`TECFD_B_SRC];
	assign run_enable            = ctrl[`TECFD_B_RUN];
	assign edge_select           = ctrl[`TECFD_B_EDGE];
	assign prescaler_ratio       = aux[`TECFD_B_PSC_HI:`TECFD_B_PSC_LO];
	assign divider_source_select = aux[`TECFD_B_DSEL];
	assign divider_output_enable = aux[`TECFD_B_DEN_HI:`TECFD_B_DEN_LO];
	assign wr_ctrl               = I_WR && (I_ADDR == `TECFD_OFS_CTRL);
	assign wr_data               = I_WR && (I_ADDR == `TECFD_OFS_DATA);

	// internal source: falling edge of clock/4, or of the synchronised crystal
	assign src_tick = clock_source_select ? (lxt_d && !lxt_s2)
	                                      : (div4 == `TECFD_DIV4_LAST);

	// prescaler fires when the low n bits wrap, so code 0 passes every tick
	assign psc_mask = PSC_W'((8'h01 << prescaler_ratio) - 8'h01);
	assign int_tick = src_tick && ((psc & psc_mask) == psc_mask);

	// timer input edges, only when the pin is an input in a pin mode
	assign tc_ok   = port[`TECFD_B_TC_DIR] && mode[0];
	assign tc_rise = tc_ok && tc_s2 && !tc_d;
	assign tc_fall = tc_ok && !tc_s2 && tc_d;

	// capture start and stop edges follow the edge select bit
	assign start_edge = edge_select ? tc_rise : tc_fall;
	assign stop_edge  = edge_select ? tc_fall : tc_rise;
	assign cap_stop   = run_enable && (mode == MODE_CAPTURE)
	                    && (cap_state == CAP_COUNT) && stop_edge;

	// count qualification per mode
	always_comb begin
		counting = 1'b0;
		tick     = 1'b0;
		unique case (mode)
			MODE_TIMER: begin
				counting = run_enable;
				tick     = run_enable && int_tick;
			end
			MODE_EVENT: begin
				counting = 1'b0;
				// edges bypass the prescaler and are counted even in sleep
				tick     = run_enable && (edge_select ? tc_fall : tc_rise);
			end
			MODE_CAPTURE: begin
				counting = run_enable && (cap_state == CAP_COUNT);
				tick     = counting && !stop_edge && int_tick;
			end
			MODE_NONE: begin
				counting = 1'b0;
				tick     = 1'b0;
			end
		endcase
	end

	// overflow and reload value; a preload written in the same cycle wins
	assign ovf    = tick && (cnt == `TECFD_CNT_FULL);
	assign reload = wr_data ? I_WDATA : preload;

	// divider source and next state
	assign sel_ovf  = divider_source_select ? I_OTHER_OVF : ovf;
	assign next_pfd = sel_ovf ? !pfd_q : pfd_q;

	// output gating: dual uses bit zero, single uses bit one
	assign pfd_act  = (divider_output_enable != 2'b00) && !port[`TECFD_B_PFD_DIR]
	                  && (divider_output_enable[1] ? port[`TECFD_B_P0]
	                                               : port[`TECFD_B_P1]);
	assign pfdn_act = divider_output_enable[1] && port[`TECFD_B_P0]
	                  && !port[`TECFD_B_PFDN_DIR];

	// clock/4 divider runs free, not restarted by counting; it stalls only while I_CE is low
	always_ff @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			div4 <= 2'h0;
		end else if (I_CE) begin
			div4 <= div4 + 2'h1;
		end
	end

	// synchronisers; the first stage feeds only the second
	always_ff @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			lxt_s1 <= 1'b0;
			lxt_s2 <= 1'b0;
			lxt_d  <= 1'b0;
			tc_s1  <= 1'b0;
			tc_s2  <= 1'b0;
			tc_d   <= 1'b0;
		end else if (I_CE) begin
			lxt_s1 <= I_LXT;
			lxt_s2 <= lxt_s1;
			lxt_d  <= lxt_s2;
			tc_s1  <= I_TC;
			tc_s2  <= tc_s1;
			tc_d   <= tc_s2;
		end
	end

	// prescaler restarts whenever counting stops so each start is clean
	always_ff @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			psc <= '0;
		end else if (I_CE) begin
			if (!counting) begin
				psc <= '0;
			end else if (src_tick) begin
				psc <= psc + PSC_W'(1);
			end
		end
	end

	// control register; software write beats the hardware stop
	always_ff @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			ctrl <= `TECFD_CTRL_RST;
		end else if (I_CE) begin
			if (wr_ctrl) begin
				ctrl <= I_WDATA & `TECFD_CTRL_MASK;
			end else if (cap_stop) begin
				ctrl[`TECFD_B_RUN] <= 1'b0;
			end
		end
	end

	// auxiliary and port registers
	always_ff @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			aux  <= `TECFD_AUX_RST;
			port <= `TECFD_PORT_RST;
		end else if (I_CE) begin
			if (I_WR && (I_ADDR == `TECFD_OFS_AUX)) begin
				aux <= I_WDATA & `TECFD_AUX_MASK;
			end
			if (I_WR && (I_ADDR == `TECFD_OFS_PORT)) begin
				port <= I_WDATA & `TECFD_PORT_MASK;
			end
		end
	end

	// preload register holds a written value until the next data write
	always_ff @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			preload <= 8'h00;
		end else if (I_CE && wr_data) begin
			preload <= I_WDATA;
		end
	end

	// counter: immediate load when off, reload on overflow
	always_ff @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			cnt <= 8'h00;
		end else if (I_CE) begin
			if (wr_data && !run_enable) begin
				cnt <= I_WDATA;
			end else if (ovf) begin
				cnt <= reload;
			end else if (tick) begin
				cnt <= cnt + 8'h01;
			end
		end
	end

	// capture sequence: arm on run, count from start edge, stop on return edge
	always_ff @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			cap_state <= CAP_IDLE;
		end else if (I_CE) begin
			if (!run_enable || (mode != MODE_CAPTURE)) begin
				cap_state <= CAP_IDLE;
			end else begin
				unique case (cap_state)
					CAP_IDLE: begin
						cap_state <= CAP_ARMED;
					end
					CAP_ARMED: begin
						if (start_edge) begin
							cap_state <= CAP_COUNT;
						end
					end
					CAP_COUNT: begin
						if (stop_edge) begin
							cap_state <= CAP_IDLE;
						end
					end
					default: begin
						cap_state <= CAP_IDLE;
					end
				endcase
			end
		end
	end

	// interrupt enable and request flag; overflow set wins over a clear
	always_ff @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			irq_enable <= 1'b0;
			irq_flag   <= 1'b0;
		end else if (I_CE) begin
			if (I_WR && (I_ADDR == `TECFD_OFS_INT)) begin
				irq_enable <= I_WDATA[`TECFD_B_IEN];
				irq_flag   <= I_WDATA[`TECFD_B_IFLAG] || ovf;
			end else if (ovf) begin
				irq_flag <= 1'b1;
			end
		end
	end

	// interrupt and wake outputs; a flag already set blocks the wake
	always_ff @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			O_IRQ  <= 1'b0;
			O_WAKE <= 1'b0;
		end else if (I_CE) begin
			O_IRQ  <= irq_flag && irq_enable;
			O_WAKE <= ovf && I_SLEEP && !irq_flag;
		end
	end

	// divider flip-flop and gated pins, outputs aligned with the toggle
	always_ff @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			pfd_q   <= 1'b0;
			O_PFD   <= 1'b0;
			O_PFD_N <= 1'b0;
		end else if (I_CE) begin
			pfd_q   <= next_pfd;
			O_PFD   <= pfd_act && next_pfd;
			O_PFD_N <= pfdn_act && !next_pfd;
		end
	end

	// read port: data stands only in the cycle after the strobe
	always_ff @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			O_RDATA <= 8'h00;
		end else if (I_CE) begin
			if (I_RD) begin
				unique case (I_ADDR)
					`TECFD_OFS_CTRL: O_RDATA <= ctrl & `TECFD_CTRL_MASK;
					`TECFD_OFS_DATA: O_RDATA <= cnt;
					`TECFD_OFS_AUX:  O_RDATA <= aux;
					`TECFD_OFS_PORT: O_RDATA <= port;
					`TECFD_OFS_INT:  O_RDATA <= {6'h00, irq_flag, irq_enable};
					default:         O_RDATA <= 8'h00;
				endcase
			end else begin
				O_RDATA <= 8'h00;
			end
		end
	end

endmodule // tecfd_timer

// [verif/tecfd_timer_asserts.sv]
// checker of the timer ports: read data, interrupt, wake and divider gating
// assumes one clock and writes taken only while I_CE is high
`timescale 1ns/100ps
`include "tecfd_consts.svh"
module tecfd_chk
	import tecfd_pkg::*;
#(
	parameter int PSC_W = 7
) (
	// clock and reset
	input wire logic                     I_CLK,
	input wire logic                     I_RESET_N,
	// register port
	input wire logic                     I_CE,
	input wire logic [`TECFD_ADDR_W-1:0] I_ADDR,
	input wire logic [7:0]               I_WDATA,
	input wire logic                     I_WR,
	input wire logic                     I_RD,
	input wire logic [7:0]               O_RDATA,
	// pins and system
	input wire logic                     I_SLEEP,
	input wire logic                     O_IRQ,
	input wire logic                     O_WAKE,
	input wire logic                     O_PFD,
	input wire logic                     O_PFD_N
);
	logic [7:0] aux;
	logic [7:0] prt;
	logic       ien;

	// mirror of gating bits; only software changes them, so bus writes suffice
	always_ff @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			aux <= `TECFD_AUX_RST;
			prt <= `TECFD_PORT_RST;
			ien <= 1'b0;
		end else if (I_WR && I_CE) begin
			if (I_ADDR == `TECFD_OFS_AUX)
				aux <= I_WDATA;
			if (I_ADDR == `TECFD_OFS_PORT)
				prt <= I_WDATA;
			if (I_ADDR == `TECFD_OFS_INT)
				ien <= I_WDATA[`TECFD_B_IEN];
		end
	end

	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (!I_RESET_N);

	ctrl_low_zero_a: assert property (
		$past(I_RD && I_ADDR == `TECFD_OFS_CTRL) |-> O_RDATA[2:0] == 3'h0)
		else $error("control low bits read nonzero");
	irq_enable_a: assert property (
		O_IRQ |-> $past(ien)) else $error("request while disabled");
	wake_sleep_a: assert property (
		O_WAKE |-> ($past(I_SLEEP) || $past(I_SLEEP, 2))) else $error("wake while awake");
	wake_pulse_a: assert property (
		O_WAKE |=> !O_WAKE) else $error("wake longer than one cycle");
	pfd_pair_a: assert property (
		!(O_PFD && O_PFD_N)) else $error("divider pair not complementary");
	pfd_gate_a: assert property (
		!$past(prt[0]) && !$past(prt[1]) |-> !O_PFD && !O_PFD_N)
		else $error("divider active with gate low");
	pfd_dir_a: assert property (
		!(O_PFD && $past(prt[3])) && !(O_PFD_N && $past(prt[4])))
		else $error("divider driven on input pin");
	pfd_off_a: assert property (
		$past(aux[5:4]) == 2'h0 |-> !O_PFD && !O_PFD_N) else $error("divider not off");
	pfd_single_a: assert property (
		$past(aux[5:4]) == 2'h1 |-> !O_PFD_N) else $error("complement in single mode");

	// main scenarios reached
	cover property (O_IRQ);
	cover property (O_WAKE);
	cover property ($rose(O_PFD));
endmodule // tecfd_chk

bind tecfd_timer tecfd_chk #(.PSC_W(PSC_W)) u_chk (
	.I_CLK(I_CLK), .I_RESET_N(I_RESET_N), .I_CE(I_CE), .I_ADDR(I_ADDR),
	.I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_SLEEP(I_SLEEP),
	.O_IRQ(O_IRQ), .O_WAKE(O_WAKE), .O_PFD(O_PFD), .O_PFD_N(O_PFD_N)
);

// [verif/tecfd_pin_model.sv]
// model of the pulse source on the timer pin and of the free-running crystal
// assumes a one-cycle go command and width held while pulses run
`timescale 1ns/100ps
module tecfd_pin_model (
	// clock and commands
	input  wire logic       i_clk,
	input  wire logic       i_go,
	input  wire logic       i_idle,
	input  wire logic [3:0] i_num,
	input  wire logic [7:0] i_width,
	// pins
	output logic            o_tc,
	output logic            o_lxt
);
	logic [7:0] cnt  = 8'h00;
	logic [4:0] half = 5'h00;
	logic [2:0] xdiv = 3'h0;

	// each pulse leaves the rest level for one width, then rests for one width
	always_ff @(posedge i_clk) begin
		if (i_go) begin
			half <= {i_num, 1'b0};
			cnt  <= i_width;
		end else if (half != 5'h00) begin
			cnt  <= (cnt == 8'h01) ? i_width : cnt - 8'h01;
			half <= (cnt == 8'h01) ? half - 5'h01 : half;
		end
	end
	assign o_tc = i_idle ^ (half != 5'h00 && !half[0]);

	// crystal keeps running, so its phase against the counter start is arbitrary
	always_ff @(posedge i_clk) begin
		xdiv <= xdiv + 3'h1;
	end
	assign o_lxt = xdiv[2];
endmodule // tecfd_pin_model

// [verif/tecfd_timer_tb.sv]
// bench of the timer block: register port tasks and one task per scenario
// assumes the pin model and the bound checker are compiled before it
`timescale 1ns/100ps
`include "tecfd_consts.svh"
module tecfd_timer_tb
	import tecfd_pkg::*;
;
	localparam logic [2:0] a_ct = `TECFD_OFS_CTRL;
	localparam logic [2:0] a_dt = `TECFD_OFS_DATA;
	localparam logic [2:0] a_ax = `TECFD_OFS_AUX;
	localparam logic [2:0] a_pt = `TECFD_OFS_PORT;
	localparam logic [2:0] a_in = `TECFD_OFS_INT;
	logic       clk   = 1'b0;
	logic       rst_n = 1'b0;
	logic [2:0] addr  = 3'h0;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata;
	logic       wr    = 1'b0;
	logic       rd    = 1'b0;
	logic       oovf  = 1'b0;
	logic       ce    = 1'b1;
	logic [2:0] obs;
	logic       sleep = 1'b0;
	logic       go    = 1'b0;
	logic       idle  = 1'b1;
	logic [3:0] num   = 4'h1;
	logic [7:0] width = 8'h14;
	logic       tc, low_speed_crystal, irq, wake, freq_divider_output, pfd_n;
	int         failures   = 0;
	int         n_compared = 0;

	always #50 clk = ~clk;

	tecfd_timer u_dut (
		.I_CLK(clk), .I_RESET_N(rst_n), .I_CE(ce), .I_ADDR(addr), .I_WDATA(wdata),
		.I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_TC(tc), .I_LXT(low_speed_crystal), .I_OTHER_OVF(oovf),
		.I_SLEEP(sleep), .O_IRQ(irq), .O_WAKE(wake), .O_PFD(freq_divider_output), .O_PFD_N(pfd_n)
	);
	tecfd_pin_model u_pin (
		.i_clk(clk), .i_go(go), .i_idle(idle), .i_num(num), .i_width(width), .o_tc(tc),
		.o_lxt(low_speed_crystal)
	);

	// watched outputs by index, so the wait task needs no reference argument
	assign obs = {wake, freq_divider_output, irq};

	task automatic end_sim();
		if (failures == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
		n_compared++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			failures++;
			$display("[ERR] %0t got %h want %h..%h", $time, got, lo, hi);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wait_eq(input int k, input logic v, input int n);
		for (int i = 0; i < n && obs[k] !== v; i++) begin
			@(posedge clk);
			#1;
		end
		chk({7'h00, obs[k]}, {7'h00, v}, {7'h00, v});
		if (obs[k] !== v)
			end_sim();
	endtask
	task automatic wrr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
	endtask
	task automatic rdc(input logic [2:0] a, input logic [7:0] lo, input logic [7:0] hi);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd   <= 1'b0;
		#1 chk(rdata, lo, hi);
	endtask
	task automatic pulse(input logic [3:0] n, input logic [7:0] w);
		@(posedge clk);
		num   <= n;
		width <= w;
		go    <= 1'b1;
		@(posedge clk);
		go    <= 1'b0;
	endtask

	// reset values, unmapped place, read-zero control bits
	task automatic t_regs();
		rdc(a_ct, 8'h08, 8'h08);
		rdc(a_pt, 8'h1c, 8'h1c);
		wrr(3'h7, 8'hff);
		rdc(3'h7, 8'h00, 8'h00);
		wrr(a_ct, 8'hff);
		rdc(a_ct, 8'hf8, 8'hf8);
	endtask
	// counter runs for w cycles from zero, then is read
	task automatic t_rate(input logic [7:0] c, input logic [2:0] p, input int w,
		input logic [7:0] e);
		wrr(a_ct, c & 8'hef);
		wrr(a_dt, 8'h00);
		wrr(a_ax, {5'h00, p});
		wrr(a_ct, c);
		cyc(w - 2);
		wrr(a_ct, c & 8'hef);
		rdc(a_dt, (e == 8'h00) ? e : e - 8'h01, (e == 8'h00) ? e : e + 8'h01);
	endtask
	// overflow, reload, interrupt and divider
	task automatic t_ovf();
		logic v;
		wrr(a_in, 8'h01);
		wrr(a_ax, 8'h20);
		wrr(a_pt, 8'h05);
		wrr(a_dt, 8'hf0);
		rdc(a_dt, 8'hf0, 8'hf0);
		wrr(a_ct, 8'h90);
		wait_eq(0, 1'b1, 100);
		rdc(a_in, 8'h03, 8'h03);
		chk({6'h00, freq_divider_output, pfd_n}, 8'h02, 8'h02);
		wrr(a_dt, 8'h10);
		rdc(a_dt, 8'hf0, 8'hf4);
		wait_eq(1, 1'b0, 100);
		chk({6'h00, freq_divider_output, pfd_n}, 8'h01, 8'h01);
		rdc(a_dt, 8'h10, 8'h11);
		wrr(a_in, 8'h00);
		wait_eq(1, 1'b1, 1100);
		cyc(3);
		chk({7'h00, irq}, 8'h00, 8'h00);
		rdc(a_in, 8'h02, 8'h02);
		wrr(a_ct, 8'h80);
		wrr(a_ax, 8'h18);
		wrr(a_pt, 8'h06);
		cyc(2);
		#1;
		v = freq_divider_output;
		@(posedge clk);
		oovf <= 1'b1;
		@(posedge clk);
		oovf <= 1'b0;
		#1 chk({6'h00, freq_divider_output, pfd_n}, {6'h00, ~v, 1'b0}, {6'h00, ~v, 1'b0});
	endtask
	// three pulses: three falls and two rises seen at read time
	task automatic t_event(input logic eg, input logic [7:0] p, input logic [7:0] e);
		wrr(a_ct, 8'h40);
		wrr(a_pt, p);
		wrr(a_dt, 8'h00);
		wrr(a_ct, {4'h5, eg, 3'h0});
		pulse(4'h3, 8'h14);
		cyc(88);
		rdc(a_dt, e, e);
		cyc(40);
		rdc(a_ct, {4'h5, eg, 3'h0}, {4'h5, eg, 3'h0});
	endtask
	// overflow in sleep with the flag clear must wake
	task automatic t_wake();
		wrr(a_ct, 8'h40);
		wrr(a_in, 8'h00);
		wrr(a_dt, 8'hfe);
		wrr(a_ct, 8'h58);
		pulse(4'h3, 8'h14);
		wait_eq(2, 1'b1, 120);
		rdc(a_in, 8'h02, 8'h02);
	endtask
	// single shot capture of a 40 cycle pulse, ten clock/4 ticks
	task automatic t_cap(input logic eg);
		wrr(a_ct, 8'hc0);
		idle <= ~eg;
		wrr(a_ax, 8'h00);
		wrr(a_dt, 8'h00);
		wrr(a_ct, {4'hd, eg, 3'h0});
		cyc(20);
		rdc(a_dt, 8'h00, 8'h00);
		pulse(4'h1, 8'h28);
		cyc(60);
		rdc(a_dt, 8'h09, 8'h0b);
		rdc(a_ct, {4'hc, eg, 3'h0}, {4'hc, eg, 3'h0});
		pulse(4'h1, 8'h28);
		cyc(90);
		rdc(a_dt, 8'h09, 8'h0b);
	endtask
	// enable low for 400 cycles freezes a running counter and its time base
	task automatic t_freeze();
		wrr(a_ct, 8'h80);
		wrr(a_dt, 8'h00);
		wrr(a_ax, 8'h00);
		wrr(a_ct, 8'h90);
		ce <= 1'b0;
		cyc(400);
		ce <= 1'b1;
		wrr(a_ct, 8'h80);
		rdc(a_dt, 8'h00, 8'h01);
	endtask

	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		for (int p = 0; p < 8; p++)
			t_rate(8'h90, p[2:0], 16 << p, 8'h04);
		t_rate(8'hb0, 3'h0, 32, 8'h04);
		t_rate(8'h10, 3'h0, 64, 8'h00);
		t_rate(8'h80, 3'h0, 64, 8'h00);
		t_ovf();
		@(posedge clk);
		sleep <= 1'b1;
		t_event(1'b1, 8'h00, 8'h00);
		t_event(1'b0, 8'h04, 8'h02);
		t_event(1'b1, 8'h04, 8'h03);
		t_wake();
		@(posedge clk);
		sleep <= 1'b0;
		t_cap(1'b0);
		t_cap(1'b1);
		t_freeze();
		end_sim();
	end
endmodule // tecfd_timer_tb
